// ---- hdl/eptm_top.sv ----
// Top: page type change and permission restriction leaf executor
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module eptm_top
	import eptm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [31:0] accumulator_reg,
	input wire logic [63:0] second_operand_reg,
	input wire logic [63:0] third_operand_reg,
	input wire logic long_mode,
	input wire logic [DESC_BITS-1:0] desc_data,
	input wire logic page_in_cache,
	input wire eptm_meta_t meta_rd,
	input wire logic owner_initialized,
	input wire eptm_env_t env,
	output logic busy,
	output logic done,
	output eptm_outcome_t outcome,
	output logic [63:0] error_code,
	output logic [63:0] fault_addr,
	output logic [11:0] flags_set,
	output logic [11:0] flags_clear,
	output logic meta_we,
	output eptm_meta_t meta_wr
);

	////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops
	logic rst_meta;
	logic rst_sync;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Sequence: latch operands, fetch descriptor, then decide
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_DECIDE
	} eptm_state_t;

	eptm_state_t state;
	eptm_state_t next_state;
	logic is_type_change;
	logic [63:0] desc_addr;
	logic [63:0] page_addr;
	logic [DESC_BITS-1:0] descriptor_scratch;

	// Next state; unknown leaves are ignored and the block stays idle
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (start && (accumulator_reg == LEAF_TYPE_CHANGE ||
					accumulator_reg == LEAF_PERM_RESTRICT))
					next_state = ST_FETCH;
			end
			ST_FETCH: next_state = ST_DECIDE;
			ST_DECIDE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Operand capture on acceptance of a leaf
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			is_type_change <= 1'b0;
			desc_addr <= 64'h0000000000000000;
			page_addr <= 64'h0000000000000000;
		end
		else if (state == ST_IDLE && next_state == ST_FETCH)
		begin
			is_type_change <= (accumulator_reg == LEAF_TYPE_CHANGE);
			desc_addr <= second_operand_reg;
			page_addr <= third_operand_reg;
		end
	end

	// Descriptor copied whole so that later checks see one snapshot
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
			descriptor_scratch <= '0;
		else if (state == ST_FETCH)
			descriptor_scratch <= desc_data;
	end

	////////////////////////////////////////////////////////////////////
	// Checks, evaluated in priority order
	logic canon_bad;
	logic [7:0] new_type;
	logic rsvd_bad;
	logic type_bad;
	logic perm_bad;
	logic cur_type_bad;
	logic desc_r;
	logic desc_w;
	logic desc_x;
	logic restrict_type_bad;
	logic operand_bad;
	logic desc_misaligned;
	logic page_misaligned;
	logic desc_fields_bad;
	logic page_invalid;
	logic gen2_fault;
	logic lock_busy;
	logic page_unmodifiable;
	logic owner_bad;
	logic tracking_clash;

	// Canonical form: bits 63..47 all equal
	always_comb
	begin
		canon_bad = long_mode &&
			(!(&desc_addr[63:47]) && (|desc_addr[63:47]) ||
			 !(&page_addr[63:47]) && (|page_addr[63:47]));
	end

	assign desc_r = descriptor_scratch[DESC_R_BIT];
	assign desc_w = descriptor_scratch[DESC_W_BIT];
	assign desc_x = descriptor_scratch[DESC_X_BIT];
	assign new_type = descriptor_scratch[DESC_PT_LSB +: 8];
	assign rsvd_bad = |(descriptor_scratch & DESC_RSVD_MASK);
	// Only trim and thread-control are legal targets
	assign type_bad = !(new_type == PT_THREAD_CTRL ||
		new_type == TRIM_PAGE_TYPE_TYPE);
	// Restriction mask with read kept but write dropped is refused
	assign perm_bad = !(!desc_r || desc_w);
	// Type change only works on regular or thread-control pages
	assign cur_type_bad = is_type_change &&
		!(meta_rd.page_type == PT_REGULAR ||
		  meta_rd.page_type == PT_THREAD_CTRL);
	// Restriction tests the current type late, after the state checks,
	// so a pending page of another type returns the error code instead
	assign restrict_type_bad = !is_type_change &&
		(meta_rd.page_type != PT_REGULAR);

	////////////////////////////////////////////////////////////////////
	// Individual checks, named so the decision chain reads in order
	// Operand faults: segment limit, locked, non-canonical
	assign operand_bad = env.seg_limit_fault || env.operand_locked ||
		env.non_canonical || canon_bad;
	// Descriptor must sit on a 64-byte boundary
	assign desc_misaligned =
		(desc_addr & DESC_ALIGN_MASK) != 64'h0;
	// Target page must sit on a 4K boundary
	assign page_misaligned =
		(page_addr & PAGE_ALIGN_MASK) != 64'h0;
	// Reserved bits first, then the leaf's own field check
	assign desc_fields_bad = rsvd_bad ||
		(is_type_change ? type_bad : perm_bad);
	// Page absent, or of a type the type change cannot start from
	assign page_invalid = !meta_rd.valid || cur_type_bad;
	// A second-generation holder faults a type change
	assign gen2_fault = env.gen2_holder && is_type_change;
	// Restriction reports that holder as a lock failure; a page being
	// written is a lock failure for both leaves
	assign lock_busy = env.gen2_holder || env.page_written;
	// Pending or modified pages must be accepted before changing again
	assign page_unmodifiable =
		meta_rd.pending || meta_rd.modified;
	// Owner structure must be initialised before its pages change
	assign owner_bad = !owner_initialized;
	// Tracking may not overlap a type change
	assign tracking_clash =
		is_type_change && env.tracking_active;

	eptm_outcome_t next_outcome;
	logic [63:0] next_error;
	logic next_zf;
	logic next_commit;
	logic next_quiet;

	// First failing check decides; faults leave everything untouched
	always_comb
	begin
		next_outcome = OUT_OK;
		next_error = ERR_NONE;
		next_zf = 1'b0;
		next_commit = 1'b0;
		next_quiet = 1'b0;
		// The chain order is the check order; do not reshuffle it
		if (operand_bad)
			next_outcome = OUT_GP;
		else if (desc_misaligned)
			next_outcome = OUT_GP;
		else if (page_misaligned)
			next_outcome = OUT_GP;
		else if (!page_in_cache)
			next_outcome = OUT_PF;
		else if (desc_fields_bad)
			next_outcome = OUT_GP;
		else if (env.gen1_conflict)
			next_outcome = OUT_GP;
		else if (page_invalid)
			next_outcome = OUT_PF;
		else if (gen2_fault)
			next_outcome = OUT_GP;
		else if (lock_busy)
		begin
			next_error = ERR_LOCK_FAIL;
			next_zf = 1'b1;
			next_quiet = 1'b1;
		end
		else if (page_unmodifiable)
		begin
			next_error = ERR_NOT_MODIFIABLE;
			next_zf = 1'b1;
			next_quiet = 1'b1;
		end
		else if (restrict_type_bad)
			next_outcome = OUT_PF;
		else if (owner_bad)
			next_outcome = OUT_GP;
		else if (tracking_clash)
			next_outcome = OUT_GP;
		else
			next_commit = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// New metadata for a committed leaf
	eptm_meta_t next_meta;

	always_comb
	begin
		next_meta = meta_rd;
		if (is_type_change)
		begin
			next_meta.restrict_prog = 1'b0;
			next_meta.modified = 1'b1;
			next_meta.r = 1'b0;
			next_meta.w = 1'b0;
			next_meta.x = 1'b0;
			next_meta.page_type = new_type;
		end
		else
		begin
			next_meta.restrict_prog = 1'b1;
			next_meta.r = meta_rd.r & desc_r;
			next_meta.w = meta_rd.w & desc_w;
			next_meta.x = meta_rd.x & desc_x;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Result registers; a fault writes no code, flags or metadata

	// Completion pulse, one cycle after the decision state
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
			done <= 1'b0;
		else
			done <= (state == ST_DECIDE);
	end

	// Outcome and fault address hold until the next completion
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			outcome <= OUT_OK;
			fault_addr <= 64'h0000000000000000;
		end
		else if (state == ST_DECIDE)
		begin
			outcome <= next_outcome;
			fault_addr <= (next_outcome == OUT_PF) ?
				page_addr : 64'h0000000000000000;
		end
	end

	// Error code moves only on a non-faulting exit, so software that
	// takes a fault still sees the code of the last completed leaf
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
			error_code <= ERR_NONE;
		else if (state == ST_DECIDE && next_outcome == OUT_OK)
			error_code <= next_error;
	end

	// Flag updates are one-cycle strobes for the status register owner
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			flags_set <= 12'h000;
			flags_clear <= 12'h000;
		end
		else if (state == ST_DECIDE && next_outcome == OUT_OK)
		begin
			flags_set <= ({11'h000, next_zf} << FL_ZF);
			flags_clear <= (12'h001 << FL_CF) | (12'h001 << FL_PF) |
				(12'h001 << FL_AF) | (12'h001 << FL_OF) |
				(12'h001 << FL_SF) |
				({11'h000, !next_zf} << FL_ZF);
		end
		else
		begin
			flags_set <= 12'h000;
			flags_clear <= 12'h000;
		end
	end

	// Metadata write strobe only for a committed leaf
	always_ff @(posedge clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			meta_we <= 1'b0;
			meta_wr <= '0;
		end
		else
		begin
			meta_we <= (state == ST_DECIDE) && next_outcome == OUT_OK &&
				next_commit && !next_quiet;
			if (state == ST_DECIDE && next_outcome == OUT_OK)
				meta_wr <= next_meta;
		end
	end

	assign busy = (state != ST_IDLE);

endmodule // eptm_top

// ---- hdl/eptm_pkg.sv ----
// Package: types and constants for the enclave page type modifier
package eptm_pkg;
	// Leaf selectors
	localparam logic [31:0] LEAF_PERM_RESTRICT = 32'h0000000e;
	localparam logic [31:0] LEAF_TYPE_CHANGE = 32'h0000000f;
	// Page types
	localparam logic [7:0] PT_REGULAR = 8'h01;
	localparam logic [7:0] PT_THREAD_CTRL = 8'h02;
	localparam logic [7:0] TRIM_PAGE_TYPE_TYPE = 8'h04;
	// Error codes returned in the accumulator
	localparam logic [63:0] ERR_NONE = 64'h0000000000000000;
	localparam logic [63:0] ERR_LOCK_FAIL = 64'h0000000000000007;
	localparam logic [63:0] ERR_NOT_MODIFIABLE = 64'h000000000000000c;
	// Alignment masks
	localparam logic [63:0] DESC_ALIGN_MASK = 64'h000000000000003f;
	localparam logic [63:0] PAGE_ALIGN_MASK = 64'h0000000000000fff;
	// Descriptor layout (512 bits)
	localparam int DESC_BITS = 512;
	localparam int DESC_R_BIT = 0;
	localparam int DESC_W_BIT = 1;
	localparam int DESC_X_BIT = 2;
	localparam int DESC_PT_LSB = 8;
	localparam logic [DESC_BITS-1:0] DESC_RSVD_MASK =
		{{(DESC_BITS-16){1'b1}}, 8'h00, 8'hf8};
	// Status flag bit positions
	localparam int FL_CF = 0;
	localparam int FL_PF = 2;
	localparam int FL_AF = 4;
	localparam int FL_ZF = 6;
	localparam int FL_SF = 7;
	localparam int FL_OF = 11;

	// Page metadata entry
	typedef struct packed {
		logic valid;
		logic pending;
		logic modified;
		logic restrict_prog;
		logic r;
		logic w;
		logic x;
		logic [7:0] page_type;
	} eptm_meta_t;

	// Concurrency and environment conditions seen by the leaf
	typedef struct packed {
		logic seg_limit_fault;
		logic operand_locked;
		logic non_canonical;
		logic gen1_conflict;
		logic gen2_holder;
		logic page_written;
		logic tracking_active;
	} eptm_env_t;

	// Outcome kinds
	typedef enum logic [1:0] {
		OUT_OK,
		OUT_GP,
		OUT_PF
	} eptm_outcome_t;
endpackage

// ---- dv/eptm_props.sv ----
// Checker: timing and outcome relations at the leaf executor ports
`timescale 1ns/1ps
module eptm_props
	import eptm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [31:0] accumulator_reg,
	input wire logic [63:0] third_operand_reg,
	input wire logic [DESC_BITS-1:0] desc_data,
	input wire logic busy,
	input wire logic done,
	input wire eptm_outcome_t outcome,
	input wire logic [63:0] error_code,
	input wire logic [63:0] fault_addr,
	input wire logic [11:0] flags_set,
	input wire logic [11:0] flags_clear,
	input wire logic meta_we,
	input wire eptm_meta_t meta_wr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic take;
	// Accepted request: idle and selector 0e or 0f
	assign take = start && !busy && accumulator_reg[31:1] == 31'h7;
	chk_done_delay: assert property (take |-> ##3 done)
		else $error("done not three cycles after start");
	chk_no_stray: assert property (done |-> $past(take, 3))
		else $error("done without accepted start");
	chk_busy_span: assert property (take |=> busy [*2] ##1 !busy)
		else $error("busy span wrong");
	chk_fault_quiet: assert property (done && outcome != OUT_OK |->
		!meta_we && flags_set == 0 && flags_clear == 0 && $stable(error_code))
		else $error("fault changed state");
	chk_pf_addr: assert property (done && outcome == OUT_PF |->
		fault_addr == $past(third_operand_reg, 3))
		else $error("page fault address wrong");
	chk_success: assert property (meta_we |-> done && outcome == OUT_OK &&
		error_code == ERR_NONE && flags_clear == 12'h8d5 && flags_set == 0)
		else $error("success exit wrong");
	chk_zf_exit: assert property (done && flags_set[FL_ZF] |-> !meta_we &&
		flags_clear == 12'h895 && (error_code == ERR_LOCK_FAIL ||
		error_code == ERR_NOT_MODIFIABLE))
		else $error("zero flag exit wrong");
	chk_type_meta: assert property (meta_we && $past(accumulator_reg[0], 3) |->
		meta_wr.modified && !meta_wr.restrict_prog && !meta_wr.r &&
		!meta_wr.w && !meta_wr.x &&
		meta_wr.page_type == $past(desc_data[15:8], 3))
		else $error("type change metadata wrong");
	cover property (meta_we);
	cover property (done && outcome == OUT_PF);
	cover property (done && flags_set[FL_ZF]);
endmodule // eptm_props
bind eptm_top eptm_props u_props (.clk, .rst_b, .start, .accumulator_reg,
	.third_operand_reg, .desc_data, .busy, .done, .outcome, .error_code,
	.fault_addr, .flags_set, .flags_clear, .meta_we, .meta_wr);

// ---- dv/eptm_meta_store.sv ----
// Partner: page metadata store read and written by the leaf executor
`timescale 1ns/1ps
module eptm_meta_store
	import eptm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire eptm_meta_t load_val,
	input wire logic meta_we,
	input wire eptm_meta_t meta_wr
	,output eptm_meta_t meta_rd
);
	// Leaf writes persist, so later requests see their side effects
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			meta_rd <= '0;
		else if (load)
			meta_rd <= load_val;
		else if (meta_we)
			meta_rd <= meta_wr;
endmodule // eptm_meta_store

// ---- dv/tb.sv ----
// Testbench: random leaf requests checked against a reference model
`timescale 1ns/1ps
module tb
	import eptm_pkg::*;
;
	typedef struct packed {eptm_outcome_t o; logic [63:0] e, f;
		logic [11:0] s, c; logic w; eptm_meta_t m;} eptm_exp_t;
	logic clk = 0, rst_b = 0, start = 0, lm = 0, pic = 0, oi = 0, ld = 0;
	logic [31:0] acc = 0, pk;
	logic [63:0] a2 = 0, a3 = 0, last_err = 0, r, ec, fa;
	logic [DESC_BITS-1:0] desc = 0;
	eptm_meta_t mrd, mwr, mld = 0;
	eptm_env_t env = 0;
	eptm_outcome_t oc;
	logic busy, done, mwe;
	logic [11:0] fs, fc;
	eptm_exp_t q[$];
	int n_fail = 0, total_checks = 0, cyc = 0;
	always #12.5 clk = ~clk;
	eptm_top DUT (.clk(clk), .rst_b(rst_b), .start(start),
		.accumulator_reg(acc), .second_operand_reg(a2),
		.third_operand_reg(a3), .long_mode(lm), .desc_data(desc),
		.page_in_cache(pic), .meta_rd(mrd), .owner_initialized(oi),
		.env(env), .busy(busy), .done(done), .outcome(oc),
		.error_code(ec), .fault_addr(fa), .flags_set(fs),
		.flags_clear(fc), .meta_we(mwe), .meta_wr(mwr));
	eptm_meta_store u_store (.clk(clk), .rst_b(rst_b), .load(ld),
		.load_val(mld), .meta_we(mwe), .meta_wr(mwr), .meta_rd(mrd));
	// Reference: checks in fixed order, first failure decides
	function automatic eptm_exp_t model();
		eptm_exp_t x;
		x = '{OUT_GP, last_err, 64'h0, 12'h0, 12'h0, 1'b0, mrd};
		if (env[6:4] != 0 || a2[5:0] != 0 || a3[11:0] != 0 || (lm &&
			(a2[63:47] != {17{a2[47]}} || a3[63:47] != {17{a3[47]}})))
			return x;
		x.o = OUT_PF;
		x.f = a3;
		if (!pic)
			return x;
		x.o = OUT_GP;
		x.f = 64'h0;
		if ((desc & DESC_RSVD_MASK) != 0 || env.gen1_conflict || (acc[0] ?
			!(desc[15:8] inside {PT_THREAD_CTRL, TRIM_PAGE_TYPE_TYPE}) :
			desc[1:0] == 2'b01))
			return x;
		x.o = OUT_PF;
		x.f = a3;
		if (!mrd.valid || (acc[0] &&
			!(mrd.page_type inside {PT_REGULAR, PT_THREAD_CTRL})))
			return x;
		x.o = OUT_GP;
		x.f = 64'h0;
		if (acc[0] && env.gen2_holder)
			return x;
		x = '{OUT_OK, ERR_LOCK_FAIL, 64'h0, 12'h040, 12'h895, 1'b0, mrd};
		if (env.page_written || env.gen2_holder)
			return x;
		x.e = ERR_NOT_MODIFIABLE;
		if (mrd.pending || mrd.modified)
			return x;
		x = '{OUT_PF, last_err, a3, 12'h0, 12'h0, 1'b0, mrd};
		if (!acc[0] && mrd.page_type != PT_REGULAR)
			return x;
		x = '{OUT_GP, last_err, 64'h0, 12'h0, 12'h0, 1'b0, mrd};
		if (!oi || (acc[0] && env.tracking_active))
			return x;
		x = '{OUT_OK, ERR_NONE, 64'h0, 12'h0, 12'h8d5, 1'b1, mrd};
		x.m.restrict_prog = !acc[0];
		x.m.modified |= acc[0];
		x.m.r &= desc[0] && !acc[0];
		x.m.w &= desc[1] && !acc[0];
		x.m.x &= desc[2] && !acc[0];
		if (acc[0])
			x.m.page_type = desc[15:8];
		return x;
	endfunction
	// One request; faults are injected with a bias of about one in eight
	task automatic op();
		eptm_exp_t x;
		r = {$urandom, $urandom};
		pk = $urandom & $urandom & $urandom;
		@(posedge clk);
		ld <= r[48];
		mld <= {~pk[14], pk[15], pk[16], r[3:0],
			r[50] ? PT_THREAD_CTRL : PT_REGULAR};
		@(posedge clk);
		ld <= 0;
		start <= 1;
		acc <= pk[20] ? ($urandom | 32'h100) : {31'h7, r[49]};
		a2 <= {{17{r[46]}}, r[46:6], pk[0], 5'h0};
		a3 <= {pk[2] ^ r[46], {16{r[46]}}, r[46:12], 11'h0, pk[1]};
		lm <= r[5];
		pic <= !pk[3];
		oi <= !pk[12];
		env <= pk[11:5];
		desc <= DESC_BITS'({pk[13] ? r[63:56] : r[4] ? TRIM_PAGE_TYPE_TYPE :
			PT_THREAD_CTRL, 4'h0, pk[4], r[2:0]});
		@(posedge clk);
		start <= pk[18];
		x = model();
		if (acc[31:1] == 31'h7)
			q.push_back(x);
		if (acc[31:1] == 31'h7 && x.o == OUT_OK)
			last_err = x.e;
		@(posedge clk);
		start <= 0;
		repeat (2) @(posedge clk);
	endtask
	task automatic fail(input string m);
		n_fail++;
		$display("ERROR %0t %s", $time, m);
	endtask
	task automatic check(input eptm_exp_t x);
		total_checks++;
		if (oc !== x.o || fa !== x.f || ec !== x.e || fs !== x.s ||
			fc !== x.c || mwe !== x.w || (x.w && mwr !== x.m))
			fail("result mismatch");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Result watcher with a cycle ceiling against hangs
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc > 4000)
		begin
			fail("timeout");
			tally_and_finish();
		end
		if (done === 1'b1 && q.size() == 0)
			fail("stray done");
		else if (done === 1'b1)
			check(q.pop_front());
	end
	initial
	begin
		void'($urandom(55457));
		repeat (16) @(posedge clk);
		rst_b <= 1;
		repeat (4) @(posedge clk);
		repeat (400) op();
		// Let the watcher take the last completion before the final count
		repeat (2) @(posedge clk);
		total_checks++;
		if (q.size() != 0)
			fail("missing done");
		tally_and_finish();
	end
endmodule // tb
